// >>> acsir_pkg.sv
// register map and field constants of the converter status block
package acsir_pkg;
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned RES_W = 10;
  localparam logic [7:0] OFS_CH_SET = 8'h10;
  localparam logic [7:0] OFS_CH_CLR = 8'h14;
  localparam logic [7:0] OFS_CH_STATE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_LAST = 8'h20;
  localparam logic [7:0] OFS_MSK_SET = 8'h24;
  localparam logic [7:0] OFS_MSK_CLR = 8'h28;
  localparam logic [7:0] OFS_MSK_STATE = 8'h2c;
  localparam logic [7:0] OFS_CH_RES0 = 8'h30;
  localparam logic [7:0] OFS_CH_RES7 = 8'h4c;
  localparam int unsigned POS_DONE = 0;
  localparam int unsigned POS_OVR = 8;
  localparam int unsigned POS_RDY = 16;
  localparam int unsigned POS_GOVR = 17;
  localparam int unsigned POS_ENDRCV = 18;
  localparam int unsigned POS_BUFFULL = 19;
  localparam int unsigned STAT_W = 20;
  localparam logic [31:0] STATUS_RST = 32'h000c_0000;
  localparam logic [19:0] MASK_RST = 20'h0_0000;
endpackage

// >>> acsir_regs.sv
// status, channel state and interrupt mask registers of the converter
`timescale 1ns/100ps
// Behaviour
// - writing one to channel enable set port enables that channel
// - writing one to channel enable clear port disables that channel
// - bit 19 follows the dma buffer-full signal
// - bit 18 follows the dma end-of-receive signal
// - bit 17 sets on general overrun, clears on status read
// - bit 16 sets on new last result, clears on last result read
// - bits 15..8 set on channel overrun, clear on status read
// - bits 7..0 set on channel done, clear on its result read or on last result read
// - done bit reads one only for enabled channel with finished conversion
// - last result captures ten bits at each conversion end and holds
// - mask set port writes of one set mask bits
// - mask clear port writes of one clear mask bits
// - mask state reads enabled sources at status bit positions
// - reset gives status 0x000c0000, other registers zero
// - channel result loads at conversion end only if channel enabled
module acsir_regs #(
  parameter int unsigned NCH = acsir_pkg::NUM_CHAN
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // conversion events from the sequencer, same clock
  input wire logic i_conv_done,
  input wire logic [2:0] i_conv_chan,
  input wire logic [9:0] i_conv_value,
  input wire logic [NCH-1:0] i_chan_overrun,
  input wire logic i_gen_overrun,
  // dma controller flags
  input wire logic i_dma_buf_full,
  input wire logic i_dma_end_rcv,
  // channel state toward the sequencer
  output logic [NCH-1:0] o_chan_enabled,
  // interrupt
  output logic o_irq
);
  // ****************************************
  // bus decode
  // ****************************************
  logic req;
  logic wr;
  logic rd;
  logic [NCH-1:0] ch_state;
  logic [NCH-1:0] done;
  logic [NCH-1:0] ovr;
  logic rdy;
  logic govr;
  logic buf_full_s1;
  logic buf_full;
  logic end_rcv_s1;
  logic end_rcv;
  logic [9:0] last;
  logic [9:0] ch_res [NCH];
  logic [19:0] mask;
  logic [31:0] status;
  logic [31:0] next_rdata;
  logic [NCH-1:0] chres_rd;
  logic [31:0] wmask;

  // a write port applies only the lanes that are selected
  function automatic logic [31:0] lanes(input logic [3:0] sel,
                                         input logic [31:0] d);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return d & m;
  endfunction

  assign wmask = lanes(i_wb_sel, i_wb_dat);
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = req & i_wb_we & i_ce;
  assign rd = req & ~i_wb_we & i_ce;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= req;
    end
  end

  // ****************************************
  // dma flag synchronisers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      buf_full_s1 <= 1'b1;
      buf_full <= 1'b1;
      end_rcv_s1 <= 1'b1;
      end_rcv <= 1'b1;
    end else if (i_ce) begin
      buf_full_s1 <= i_dma_buf_full;
      buf_full <= buf_full_s1;
      end_rcv_s1 <= i_dma_end_rcv;
      end_rcv <= end_rcv_s1;
    end
  end

  // ****************************************
  // channel state
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ch_state <= '0;
    end else if (wr && i_wb_adr == acsir_pkg::OFS_CH_SET) begin
      ch_state <= ch_state | wmask[NCH-1:0];
    end else if (wr && i_wb_adr == acsir_pkg::OFS_CH_CLR) begin
      ch_state <= ch_state & ~wmask[NCH-1:0];
    end
  end
  assign o_chan_enabled = ch_state;

  // ****************************************
  // results
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      last <= '0;
    end else if (i_ce && i_conv_done) begin
      last <= i_conv_value;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic hit;
      assign hit = i_conv_done && i_conv_chan == 3'(g) && ch_state[g];
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          ch_res[g] <= '0;
        end else if (i_ce && hit) begin
          ch_res[g] <= i_conv_value;
        end
      end
      assign chres_rd[g] = rd &&
        i_wb_adr == 8'(acsir_pkg::OFS_CH_RES0 + 8'(4 * g));
      // done flag: set wins over clear; disabled channel reads zero
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          done[g] <= 1'b0;
        end else if (i_ce) begin
          if (hit) begin
            done[g] <= 1'b1;
          end else if (!ch_state[g]) begin
            done[g] <= 1'b0;
          end else if (chres_rd[g] ||
                       (rd && i_wb_adr == acsir_pkg::OFS_LAST)) begin
            done[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // sticky status flags
  // ****************************************
  logic st_rd;
  assign st_rd = rd && i_wb_adr == acsir_pkg::OFS_STATUS;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ovr <= '0;
      govr <= 1'b0;
    end else if (i_ce) begin
      ovr <= i_chan_overrun | (st_rd ? '0 : ovr);
      govr <= i_gen_overrun | (govr & ~st_rd);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rdy <= 1'b0;
    end else if (i_ce) begin
      rdy <= i_conv_done |
             (rdy & ~(rd && i_wb_adr == acsir_pkg::OFS_LAST));
    end
  end

  // ****************************************
  // interrupt mask
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mask <= acsir_pkg::MASK_RST;
    end else if (wr && i_wb_adr == acsir_pkg::OFS_MSK_SET) begin
      mask <= mask | wmask[19:0];
    end else if (wr && i_wb_adr == acsir_pkg::OFS_MSK_CLR) begin
      mask <= mask & ~wmask[19:0];
    end
  end

  always_comb begin
    status = '0;
    status[acsir_pkg::POS_DONE +: 8] = 8'(done & ch_state);
    status[acsir_pkg::POS_OVR +: 8] = 8'(ovr);
    status[acsir_pkg::POS_RDY] = rdy;
    status[acsir_pkg::POS_GOVR] = govr;
    status[acsir_pkg::POS_ENDRCV] = end_rcv;
    status[acsir_pkg::POS_BUFFULL] = buf_full;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(status[19:0] & mask);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    next_rdata = '0;
    case (i_wb_adr)
      acsir_pkg::OFS_CH_STATE: next_rdata = 32'(ch_state);
      acsir_pkg::OFS_STATUS: next_rdata = status;
      acsir_pkg::OFS_LAST: next_rdata = 32'(last);
      acsir_pkg::OFS_MSK_STATE: next_rdata = 32'(mask);
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (chres_rd[i]) begin
            next_rdata = 32'(ch_res[i]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wb_dat <= '0;
    end else if (rd) begin
      o_wb_dat <= next_rdata;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_ch_set;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr && i_wb_adr == acsir_pkg::OFS_CH_SET && i_wb_sel[0])
      |=> ((ch_state & $past(i_wb_dat[7:0])) == $past(i_wb_dat[7:0]));
  endproperty
  a_ch_set: assert property (p_ch_set) else $error("chan set lost");

  property p_ch_clr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr && i_wb_adr == acsir_pkg::OFS_CH_CLR && i_wb_sel[0])
      |=> ((ch_state & $past(i_wb_dat[7:0])) == 8'h00);
  endproperty
  a_ch_clr: assert property (p_ch_clr) else $error("chan clr lost");

  property p_buf;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ($past(i_ce) && $past(i_ce, 2))
      |-> status[19] == $past(i_dma_buf_full, 2);
  endproperty
  a_buf: assert property (p_buf) else $error("buf full wrong");

  property p_end;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ($past(i_ce) && $past(i_ce, 2))
      |-> status[18] == $past(i_dma_end_rcv, 2);
  endproperty
  a_end: assert property (p_end) else $error("end rcv wrong");

  property p_govr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_ce && i_gen_overrun) |=> govr;
  endproperty
  a_govr: assert property (p_govr) else $error("govr not set");

  property p_rdy;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_ce && i_conv_done) |=> rdy && last == $past(i_conv_value);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready or last bad");

  property p_ovr_clr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (st_rd && i_chan_overrun == '0) |=> ovr == '0;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("ovr kept");

  property p_done_off;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      i_ce |=> (done & ~$past(ch_state)) == '0;
  endproperty
  a_done_off: assert property (p_done_off) else $error("done on off");

  property p_irq;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      i_ce |=> o_irq == |($past(status[19:0]) & $past(mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_msk;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr && i_wb_adr == acsir_pkg::OFS_MSK_SET && i_wb_sel[0])
      |=> mask[7:0] == ($past(mask[7:0]) | $past(i_wb_dat[7:0]));
  endproperty
  a_msk: assert property (p_msk) else $error("mask set bad");

  c_conv: cover property (@(posedge i_clk_sys) i_conv_done ##1 rdy);
  c_irq: cover property (@(posedge i_clk_sys) !o_irq ##1 o_irq);
  property p_rdy_clr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (rd && i_wb_adr == acsir_pkg::OFS_LAST && !i_conv_done) |=> !rdy;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready kept");

  property p_done_set;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_ce && i_conv_done && ch_state[i_conv_chan])
      |=> done[$past(i_conv_chan)];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done lost");

  property p_last;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      !(i_ce && i_conv_done) |=> $stable(last);
  endproperty
  a_last: assert property (p_last) else $error("last moved");

  property p_msk_clr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr && i_wb_adr == acsir_pkg::OFS_MSK_CLR && i_wb_sel[0])
      |=> (mask[7:0] & $past(i_wb_dat[7:0])) == 8'h00;
  endproperty
  a_msk_clr: assert property (p_msk_clr) else $error("mask clr");

  property p_res_keep;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_ce && i_conv_done && !ch_state[i_conv_chan])
      |=> ch_res[$past(i_conv_chan)] == $past(ch_res[i_conv_chan]);
  endproperty
  a_res_keep: assert property (p_res_keep) else $error("res moved");

  property p_ro_wr;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr && i_wb_adr == acsir_pkg::OFS_CH_STATE) |=> $stable(ch_state);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("ro write took");

  property p_msk_rd;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (rd && i_wb_adr == acsir_pkg::OFS_MSK_STATE)
      |=> o_wb_dat == {12'h000, $past(mask)};
  endproperty
  a_msk_rd: assert property (p_msk_rd) else $error("mask read bad");

  property p_rst;
    @(posedge i_clk_sys)
      !i_rst_b |=> status == acsir_pkg::STATUS_RST && ch_state == '0
      && mask == acsir_pkg::MASK_RST && !o_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state bad");

  c_rd: cover property (@(posedge i_clk_sys) st_rd ##1 o_wb_ack);
  c_ovr: cover property (@(posedge i_clk_sys) st_rd && ovr != '0);
  c_off: cover property (@(posedge i_clk_sys)
    i_conv_done && !ch_state[i_conv_chan]);
endmodule

// >>> acsir_seq_model.sv
// sequencer and dma controller model driving the block's event inputs
`timescale 1ns/100ps
module acsir_seq_model (
  // clock
  input wire logic i_clk_sys,
  // conversion events
  output logic o_done = 1'b0,
  output logic [2:0] o_chan = 3'h0,
  output logic [9:0] o_value = 10'h000,
  output logic [7:0] o_ovr = 8'h00,
  output logic o_govr = 1'b0,
  // dma flags
  output logic o_buf_full = 1'b1,
  output logic o_end_rcv = 1'b1
);
  // one conversion pulse, never beside a channel state write
  task automatic convert(input logic [2:0] c, input logic [9:0] v);
    @(posedge i_clk_sys);
    o_done <= 1'b1;
    o_chan <= c;
    o_value <= v;
    @(posedge i_clk_sys);
    o_done <= 1'b0;
    o_chan <= ~c;
    o_value <= ~v;
  endtask
  task automatic overrun(input logic [7:0] o, input logic g);
    @(posedge i_clk_sys);
    o_ovr <= o;
    o_govr <= g;
    @(posedge i_clk_sys);
    o_ovr <= 8'h00;
    o_govr <= 1'b0;
  endtask
  task automatic dma(input logic b, input logic e);
    @(posedge i_clk_sys);
    o_buf_full <= b;
    o_end_rcv <= e;
  endtask
endmodule

// >>> adc_status_interrupt_regs_bench.sv
// testbench of the converter status and interrupt registers
`timescale 1ns/100ps
module adc_status_interrupt_regs_bench;
  // ****************
  // signals
  // ****************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, done, govr, bfull, erx, irq;
  logic [2:0] chan;
  logic [9:0] value;
  logic [7:0] ovr, chen;
  logic [7:0] ro[4] = '{8'h18, 8'h1c, 8'h20, 8'h2c};
  logic [7:0] wo[5] = '{8'h10, 8'h14, 8'h24, 8'h28, 8'h80};
  int errors = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  acsir_regs dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_conv_done(done), .i_conv_chan(chan), .i_conv_value(value),
    .i_chan_overrun(ovr), .i_gen_overrun(govr), .i_dma_buf_full(bfull),
    .i_dma_end_rcv(erx), .o_chan_enabled(chen), .o_irq(irq));
  acsir_seq_model model (.i_clk_sys(clk), .o_done(done), .o_chan(chan),
    .o_value(value), .o_ovr(ovr), .o_govr(govr), .o_buf_full(bfull),
    .o_end_rcv(erx));
  // ****************
  // bus tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (ack !== 1'b1) chk({31'h0, ack}, 32'h0000_0001);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ro[i]) rd(ro[i], (i == 1) ? 32'h000c_0000 : 32'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
    wr(8'h10, 32'h0000_0081);
    rd(8'h18, 32'h0000_0081);
    wr(8'h14, 32'h0000_0001);
    rd(8'h18, 32'h0000_0080);
    chk({24'h0, chen}, 32'h0000_0080);
    model.dma(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    rd(8'h1c, 32'h0004_0000);
    model.dma(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rd(8'h1c, 32'h0000_0000);
    $display("test channels and dma done");
    wr(8'h24, 32'h000f_ffff);
    rd(8'h2c, 32'h000f_ffff);
    wr(8'h28, 32'h000f_0000);
    wr(8'h24, 32'h0000_0000);
    wr(8'h28, 32'h0000_0000);
    rd(8'h2c, 32'h0000_ffff);
    $display("test mask done");
    model.convert(3'h7, 10'h2a5);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h1c, 32'h0001_0080);
    rd(8'h4c, 32'h0000_02a5);
    rd(8'h1c, 32'h0001_0000);
    rd(8'h20, 32'h0000_02a5);
    rd(8'h1c, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    model.convert(3'h7, 10'h1c3);
    rd(8'h20, 32'h0000_01c3);
    rd(8'h1c, 32'h0000_0000);
    model.convert(3'h0, 10'h15a);
    rd(8'h1c, 32'h0001_0000);
    rd(8'h30, 32'h0000_0000);
    rd(8'h20, 32'h0000_015a);
    $display("test conversions done");
    model.overrun(8'h05, 1'b1);
    rd(8'h1c, 32'h0002_0500);
    rd(8'h1c, 32'h0000_0000);
    $display("test overruns done");
    foreach (ro[i]) wr(ro[i], 32'hffff_ffff);
    rd(8'h18, 32'h0000_0080);
    rd(8'h2c, 32'h0000_ffff);
    rd(8'h20, 32'h0000_015a);
    rd(8'h1c, 32'h0000_0000);
    foreach (wo[i]) rd(wo[i], 32'h0000_0000);
    $display("test access kinds done");
    give_verdict();
  end
endmodule
